// >>> hdl/dfe_pkg.sv
package dfe_pkg;
  // Entry geometry in bytes
  localparam int unsigned ENTRY_BYTES = 112;
  localparam int unsigned NAME_BYTES = 56;
  localparam int unsigned OFS_START = 56;
  localparam int unsigned OFS_BLKCNT = 64;
  localparam int unsigned OFS_SIZE = 72;
  localparam int unsigned OFS_DATE = 80;
  localparam int unsigned OFS_CTIME = 88;
  localparam int unsigned OFS_TTYPE = 96;
  localparam int unsigned OFS_RSVD = 97;
  localparam int unsigned OFS_CLOSE = 104;
  // Fill and code values
  localparam logic [7:0] FILL_FF = 8'hFF;
  localparam logic [7:0] FILL_00 = 8'h00;
  localparam logic [7:0] FILL_DASH = 8'h2D;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] TT_UTC = 8'h00;
  localparam logic [7:0] TT_SYS = 8'h01;
  localparam logic [7:0] TT_PKT = 8'hFF;
  localparam logic [63:0] BLKCNT_DELETED = 64'h0000000000000000;
  // Directory placement
  localparam logic [63:0] PRIMARY_DIR_ADDR = 64'h0000000000000001;
  localparam int unsigned MAX_FILES = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned SLOT_W = 16;
  localparam int unsigned SEQ_DIGITS = 8;
  localparam logic [7:0] BYTE_IDX_INIT = 8'h00;
  localparam logic [7:0] LAST_BYTE = 8'h6F;
  // Builder states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_EMIT = 2'b10
  } dfe_state_type;
endpackage

// >>> hdl/dfe_entry_builder.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Block count stored as eight bytes
// RULE2: Byte size bounded; unused size all FF
// RULE3: Creation date as DDMMYYYY digit characters
// RULE4: Unknown date/time characters written as 2D
// RULE5: Creation time as HHMMSSss digit characters
// RULE6: Close time uses same HHMMSSss layout
// RULE7: Time qualifier only 00, 01 or FF
// RULE8: Reserved bytes always filled with FF
// RULE9: Unique names; default decimal counter from one
// RULE10: Refuse entries with overlapping block ranges
// RULE11: Entries placed in order, fill each block
// RULE12: No order assumed between slot and region
// RULE13: Entry fields packed back to back
// RULE14: Reader ignores unclaimed media regions
// RULE15: Deleted entry marked by zero block count
// RULE16: Entry count includes live and deleted
// RULE17: Directory fields emitted MSB byte first
// RULE18: Packet structures little endian; payload native
// RULE19: Character fields use basic subset only
// RULE20: Name 56 bytes zero padded, then start
// RULE21: Block size taken from directory field
// RULE22: Entry streamed one byte per cycle
// RULE23: Error flag on refused entry, no output
module dfe_entry_builder (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_REQ,
  input wire logic I_NAME_VALID,
  input wire logic [447:0] I_NAME,
  input wire logic [63:0] I_START_ADDR,
  input wire logic [63:0] I_BLOCK_COUNT,
  input wire logic I_SIZE_VALID,
  input wire logic [63:0] I_BYTE_LENGTH,
  input wire logic [31:0] I_BLOCK_BYTES,
  input wire logic [63:0] I_DATE_CHARS,
  input wire logic [7:0] I_DATE_KNOWN,
  input wire logic [63:0] I_CTIME_CHARS,
  input wire logic [7:0] I_CTIME_KNOWN,
  input wire logic [63:0] I_CLOSE_CHARS,
  input wire logic [7:0] I_CLOSE_KNOWN,
  input wire logic [7:0] I_TIME_TYPE,
  input wire logic [15:0] I_SLOTS_PER_BLOCK,
  input wire logic I_DELETE,
  input wire logic [dfe_pkg::IDX_W-1:0] I_DELETE_INDEX,
  input wire logic I_OUT_READY,
  output logic O_BUSY,
  output logic O_BYTE_VALID,
  output logic [7:0] O_BYTE,
  output logic O_LAST,
  output logic O_DONE,
  output logic O_ERROR,
  output logic [63:0] O_DIR_BLOCK_INDEX,
  output logic [15:0] O_SLOT_INDEX,
  output logic [15:0] O_ENTRY_COUNT
);
  import dfe_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State declarations
  // Sequencer and entry image
  dfe_state_type state_q, state_d; // Builder sequencer
  logic [ENTRY_BYTES*8-1:0] entry_q, entry_d; // Assembled entry image
  // Stream position runs one past the last byte once done
  logic [7:0] byte_idx_q, byte_idx_d; // Next byte to stream
  logic [63:0] tbl_start_q [MAX_FILES]; // Start of each recorded range
  logic [63:0] tbl_cnt_q [MAX_FILES]; // Count of each recorded range
  logic [447:0] tbl_name_q [MAX_FILES]; // Name of each entry
  // Next values of the entry table
  logic [63:0] tbl_start_d [MAX_FILES]; // Next start of each range
  logic [63:0] tbl_cnt_d [MAX_FILES]; // Next count of each range
  logic [447:0] tbl_name_d [MAX_FILES]; // Next name of each entry
  // Directory placement counters
  logic [CNT_W-1:0] used_q, used_d; // Entries written so far
  logic [SLOT_W-1:0] slot_q, slot_d; // Slot within current block
  logic [63:0] dir_q, dir_d; // Directory block in the chain
  logic [15:0] ecount_q, ecount_d; // Entries held in current block
  logic [31:0] seq_q, seq_d; // Default name counter
  // Output flops, each drives one port
  logic busy_q, busy_d; // Checking or streaming
  logic valid_q, valid_d; // Stream byte qualifier
  logic [7:0] byte_q, byte_d; // Stream byte
  logic last_q, last_d; // Final byte of the entry
  logic done_q, done_d; // Entry complete pulse
  logic err_q, err_d; // Refusal pulse

  //////////////////////////////////////////////////////////////////////////////
  // Combinational helpers
  // Request checks against the stored table
  logic [447:0] eff_name; // Name actually used
  logic [MAX_FILES-1:0] clash; // Per-entry overlap or name match
  // Size bound against the reserved blocks
  logic [95:0] cap_bytes; // Reserved blocks times block size
  logic bad_size; // Byte length beyond the reserved space
  logic [63:0] seq_chars; // Default name as decimal digits

  // Decimal digits of the default name, most significant first
  // Eight digits cover every count the table can reach
  always_comb begin
    logic [31:0] v;
    v = seq_q;
    seq_chars = '0;
    // Peel off the lowest digit on each pass
    for (int k = 0; k < SEQ_DIGITS; k++) begin
      seq_chars[k*8 +: 8] = CHAR_ZERO + 8'(v % 10);
      v = v / 10;
    end
  end

  // Default name: decimal counter, leading zeros dropped, zero padded
  always_comb begin
    logic started;
    logic [6:0] pos;
    // Name field is zero padded beyond the digits
    eff_name = '0;
    started = 1'b0;
    pos = '0;
    if (I_NAME_VALID) begin
      // Supplied name taken as given; the caller pads it
      eff_name = I_NAME;
    end else begin
      for (int k = SEQ_DIGITS - 1; k >= 0; k--) begin
        // Leading zeros skipped, the units digit always kept
        if (seq_chars[k*8 +: 8] != CHAR_ZERO || k == 0) begin
          started = 1'b1;
        end
        // Digits fill the field from byte 0 downward
        if (started) begin
          eff_name[447 - pos*8 -: 8] = seq_chars[k*8 +: 8]; // RULE9
          pos = pos + 7'd1;
        end
      end
    end
  end

  // Compare the request against every live entry
  generate
    // One comparator per table entry
    for (genvar g = 0; g < MAX_FILES; g++) begin : g_clash
      logic live;
      logic overlap;
      // Unused and deleted slots never raise a clash; deleted ones still count toward a full table
      assign live = (g < used_q) && (tbl_cnt_q[g] != BLKCNT_DELETED); // RULE15
      // Half-open ranges; every live entry is compared, whatever its slot
      assign overlap = (I_START_ADDR < tbl_start_q[g] + tbl_cnt_q[g]) &&
                       (tbl_start_q[g] < I_START_ADDR + I_BLOCK_COUNT); // RULE10 RULE12
      assign clash[g] = live && (overlap || tbl_name_q[g] == eff_name); // RULE9
    end
  endgenerate

  // Size bound uses the directory's block size field
  // Product kept at 96 bits so a large count cannot wrap
  assign cap_bytes = I_BLOCK_COUNT * {32'h00000000, I_BLOCK_BYTES}; // RULE21
  assign bad_size = I_SIZE_VALID && ({32'h00000000, I_BYTE_LENGTH} > cap_bytes); // RULE2

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // Scratch images of the three time fields
    logic [63:0] dt, ct, cl;
    dt = '0;
    ct = '0;
    cl = '0;
    // Hold every register unless a branch below moves it
    state_d = state_q;
    entry_d = entry_q;
    byte_idx_d = byte_idx_q;
    tbl_start_d = tbl_start_q;
    tbl_cnt_d = tbl_cnt_q;
    tbl_name_d = tbl_name_q;
    used_d = used_q;
    slot_d = slot_q;
    dir_d = dir_q;
    ecount_d = ecount_q;
    seq_d = seq_q;
    // Pulses and the valid flag drop unless set below
    valid_d = 1'b0;
    byte_d = byte_q;
    last_d = 1'b0;
    done_d = 1'b0;
    err_d = 1'b0;
    // Per-character dash for unknown date and time positions
    // Each position dashed on its own, so partly known fields work
    for (int k = 0; k < 8; k++) begin
      dt[k*8 +: 8] = I_DATE_KNOWN[k] ? I_DATE_CHARS[k*8 +: 8] : FILL_DASH; // RULE3 RULE4 RULE19
      ct[k*8 +: 8] = I_CTIME_KNOWN[k] ? I_CTIME_CHARS[k*8 +: 8] : FILL_DASH; // RULE5 RULE4
      cl[k*8 +: 8] = I_CLOSE_KNOWN[k] ? I_CLOSE_CHARS[k*8 +: 8] : FILL_DASH; // RULE6 RULE4
    end
    // Sequencer: idle, check, then emit
    unique case (state_q)
      ST_IDLE: begin
        // A delete of a written entry wins over a request in the same cycle
        if (I_DELETE && ({1'b0, I_DELETE_INDEX} < used_q)) begin
          // Deletion keeps the slot, so the entry count is unchanged
          tbl_cnt_d[I_DELETE_INDEX] = BLKCNT_DELETED; // RULE15 RULE16
        end else if (I_REQ) begin
          // Inputs stay stable until the answer, so nothing is latched here
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Refuse overlap, duplicate name, oversize, full table or reserved qualifier
        if (clash != '0 || bad_size || used_q == CNT_W'(MAX_FILES) ||
            I_TIME_TYPE inside {[8'h02:8'hFE]}) begin
          // Nothing is stored and no byte is sent
          err_d = 1'b1; // RULE23 RULE7
          state_d = ST_IDLE;
        end else begin
          // Field image, most significant byte at byte 0
          entry_d[(ENTRY_BYTES-OFS_START)*8 +: NAME_BYTES*8] = eff_name; // RULE20 RULE13 RULE17
          entry_d[(ENTRY_BYTES-OFS_BLKCNT)*8 +: 64] = I_START_ADDR; // RULE20
          entry_d[(ENTRY_BYTES-OFS_SIZE)*8 +: 64] = I_BLOCK_COUNT; // RULE1
          entry_d[(ENTRY_BYTES-OFS_DATE)*8 +: 64] = I_SIZE_VALID ? I_BYTE_LENGTH : {8{FILL_FF}}; // RULE2
          // Time fields: first character lands in the highest byte
          entry_d[(ENTRY_BYTES-OFS_CTIME)*8 +: 64] = {dt[7:0], dt[15:8], dt[23:16], dt[31:24],
                                                      dt[39:32], dt[47:40], dt[55:48], dt[63:56]};
          entry_d[(ENTRY_BYTES-OFS_TTYPE)*8 +: 64] = {ct[7:0], ct[15:8], ct[23:16], ct[31:24],
                                                      ct[39:32], ct[47:40], ct[55:48], ct[63:56]};
          // Qualifier, reserved fill and close time end the entry
          entry_d[(ENTRY_BYTES-OFS_RSVD)*8 +: 8] = I_TIME_TYPE; // RULE7
          entry_d[(ENTRY_BYTES-OFS_CLOSE)*8 +: 56] = {7{FILL_FF}}; // RULE8
          entry_d[0 +: 64] = {cl[7:0], cl[15:8], cl[23:16], cl[31:24],
                              cl[39:32], cl[47:40], cl[55:48], cl[63:56]}; // RULE6
          // Record range and name for later checks
          tbl_start_d[used_q[IDX_W-1:0]] = I_START_ADDR;
          tbl_cnt_d[used_q[IDX_W-1:0]] = I_BLOCK_COUNT;
          tbl_name_d[used_q[IDX_W-1:0]] = eff_name;
          used_d = used_q + CNT_W'(1);
          // Only a consumed default name advances the counter
          if (!I_NAME_VALID) begin
            seq_d = seq_q + 32'h00000001; // RULE9
          end
          // Stream starts at byte 0 on the next cycle
          byte_idx_d = BYTE_IDX_INIT;
          state_d = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (valid_q && !I_OUT_READY) begin
          // Sink stalled: byte, valid and last stand unchanged
          valid_d = valid_q; // RULE22
          last_d = last_q;
        end else if (last_q) begin
          // Last byte taken: the entry is complete
          state_d = ST_IDLE;
          done_d = 1'b1; // RULE22
          // Fill the current block before moving down the chain
          if (slot_q + SLOT_W'(1) >= I_SLOTS_PER_BLOCK) begin
            slot_d = '0; // RULE11
            dir_d = dir_q + 64'h0000000000000001;
            ecount_d = '0;
          end else begin
            slot_d = slot_q + SLOT_W'(1); // RULE11
            ecount_d = ecount_q + 16'h0001; // RULE16
          end
        end else begin
          // Launch the next byte; the last one stands until it is taken
          // Directory entries go out big endian; packet byte order never applies here
          valid_d = 1'b1;
          byte_d = entry_q[(ENTRY_BYTES*8-1) - byte_idx_q*8 -: 8]; // RULE22 RULE17 RULE18
          last_d = (byte_idx_q == LAST_BYTE);
          byte_idx_d = byte_idx_q + 8'h01;
        end
      end
      // Unused code falls back to idle
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Busy follows the next state so it rises with the take
    busy_d = (state_d != ST_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      // Sequencer and stream position
      state_q <= ST_IDLE;
      entry_q <= '0;
      byte_idx_q <= BYTE_IDX_INIT;
      // Entry table empty
      for (int k = 0; k < MAX_FILES; k++) begin
        tbl_start_q[k] <= '0;
        tbl_cnt_q[k] <= '0;
        tbl_name_q[k] <= '0;
      end
      // Directory position at the primary block
      used_q <= '0;
      slot_q <= '0;
      dir_q <= PRIMARY_DIR_ADDR; // RULE11
      ecount_q <= '0;
      // Default name counter starts at one
      seq_q <= 32'h00000001; // RULE9
      // Outputs idle
      busy_q <= 1'b0;
      valid_q <= 1'b0;
      byte_q <= FILL_00;
      last_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      // Sequencer and stream position
      state_q <= state_d;
      entry_q <= entry_d;
      byte_idx_q <= byte_idx_d;
      // Entry table
      tbl_start_q <= tbl_start_d;
      tbl_cnt_q <= tbl_cnt_d;
      tbl_name_q <= tbl_name_d;
      // Placement and naming
      used_q <= used_d;
      slot_q <= slot_d;
      dir_q <= dir_d;
      ecount_q <= ecount_d;
      seq_q <= seq_d;
      // Output flops
      busy_q <= busy_d;
      valid_q <= valid_d;
      byte_q <= byte_d;
      last_q <= last_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign O_BUSY = busy_q;
  // Stream handshake
  assign O_BYTE_VALID = valid_q;
  assign O_BYTE = byte_q;
  assign O_LAST = last_q;
  // Completion and refusal pulses
  assign O_DONE = done_q;
  assign O_ERROR = err_q;
  // Directory position for the media manager
  assign O_DIR_BLOCK_INDEX = dir_q;
  assign O_SLOT_INDEX = slot_q;
  assign O_ENTRY_COUNT = ecount_q;
endmodule
`default_nettype wire

// >>> tb/dfe_media_sink.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Storage-side sink: shifts in entry bytes and can stall
module dfe_media_sink (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic o_ready,
  output logic [895:0] o_img
);
  logic [1:0] ph_q; // Stall phase
  // Slow media takes one byte in four cycles
  assign o_ready = !i_slow || (ph_q == 2'h3);
  // Store bytes by arrival only; no meaning read into slot or region
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_q <= 2'h0;
      o_img <= '0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (i_valid && o_ready) begin
        o_img <= {o_img[887:0], i_byte};
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/dfe_entry_builder_sva.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Port-level checks of the entry builder
module dfe_sva (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_REQ,
  input wire logic I_DELETE,
  input wire logic I_SIZE_VALID,
  input wire logic [63:0] I_BYTE_LENGTH,
  input wire logic [63:0] I_BLOCK_COUNT,
  input wire logic [31:0] I_BLOCK_BYTES,
  input wire logic [7:0] I_TIME_TYPE,
  input wire logic [15:0] I_SLOTS_PER_BLOCK,
  input wire logic I_OUT_READY,
  input wire logic O_BUSY,
  input wire logic O_BYTE_VALID,
  input wire logic [7:0] O_BYTE,
  input wire logic O_LAST,
  input wire logic O_DONE,
  input wire logic O_ERROR,
  input wire logic [15:0] O_SLOT_INDEX
);
  logic [6:0] cnt_q; // Byte position in entry
  logic [6:0] cnt_d;
  logic take; // Request taken in idle
  // Next byte position
  always_comb begin
    cnt_d = cnt_q;
    if (O_BYTE_VALID && I_OUT_READY) begin
      cnt_d = O_LAST ? 7'h00 : cnt_q + 7'h01;
    end
  end
  // Register position
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign take = I_REQ && !I_DELETE && !O_BUSY && !O_BYTE_VALID && !O_DONE && !O_ERROR;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  property p_hold; O_BYTE_VALID && !I_OUT_READY |=> O_BYTE_VALID && $stable(O_BYTE) && $stable(O_LAST); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_answer; take |-> ##[1:3] (O_ERROR || O_BYTE_VALID); endproperty
  a_answer: assert property (p_answer) else $error("no answer to request");
  property p_err; O_ERROR |-> !O_BYTE_VALID ##1 !O_ERROR && !O_BYTE_VALID; endproperty
  a_err: assert property (p_err) else $error("refused entry streamed");
  property p_size; take && I_SIZE_VALID && ({32'h0, I_BYTE_LENGTH} > {32'h0, I_BLOCK_COUNT} * {64'h0, I_BLOCK_BYTES})
    |-> ##[1:3] O_ERROR; endproperty
  a_size: assert property (p_size) else $error("oversize not refused");
  property p_ttype; take && (I_TIME_TYPE inside {[8'h02:8'hFE]}) |-> ##[1:3] O_ERROR; endproperty
  a_ttype: assert property (p_ttype) else $error("reserved time type taken");
  property p_last; O_BYTE_VALID |-> (O_LAST == (cnt_q == 7'h6F)); endproperty
  a_last: assert property (p_last) else $error("entry length wrong");
  property p_done; O_BYTE_VALID && O_LAST && I_OUT_READY |=> O_DONE ##1 !O_DONE; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_rsvd; O_BYTE_VALID && (cnt_q inside {[7'h61:7'h67]}) |-> O_BYTE == 8'hFF; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not FF");
  property p_tcode; O_BYTE_VALID && cnt_q == 7'h60 |-> O_BYTE inside {8'h00, 8'h01, 8'hFF}; endproperty
  a_tcode: assert property (p_tcode) else $error("time code reserved");
  property p_slot; O_SLOT_INDEX < I_SLOTS_PER_BLOCK; endproperty
  a_slot: assert property (p_slot) else $error("slot beyond block");
  c_err: cover property (take ##[1:3] O_ERROR);
  c_stall: cover property (O_BYTE_VALID && !I_OUT_READY);
  c_done: cover property (O_DONE);
endmodule
bind dfe_entry_builder dfe_sva u_sva (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_REQ(I_REQ),
  .I_DELETE(I_DELETE), .I_SIZE_VALID(I_SIZE_VALID), .I_BYTE_LENGTH(I_BYTE_LENGTH),
  .I_BLOCK_COUNT(I_BLOCK_COUNT), .I_BLOCK_BYTES(I_BLOCK_BYTES), .I_TIME_TYPE(I_TIME_TYPE),
  .I_SLOTS_PER_BLOCK(I_SLOTS_PER_BLOCK), .I_OUT_READY(I_OUT_READY), .O_BUSY(O_BUSY),
  .O_BYTE_VALID(O_BYTE_VALID), .O_BYTE(O_BYTE), .O_LAST(O_LAST), .O_DONE(O_DONE),
  .O_ERROR(O_ERROR), .O_SLOT_INDEX(O_SLOT_INDEX));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Self-checking bench of the entry builder
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, req = 1'b0, nv = 1'b0, sv = 1'b0, del = 1'b0, slow = 1'b0;
  logic [447:0] nm = '0;
  logic [63:0] st = '0, bc = '0, len = '0, dt = '0, ct = '0, cl = '0, dir;
  logic [7:0] dk = '0, ck = '0, lk = '0, tt = '0, ob;
  logic [2:0] di = 3'h0;
  logic rdy, busy, ov, last, done, err;
  logic [15:0] slot, ecnt;
  logic [895:0] img;
  int seed = 32'h738c8c60, bad_count = 0, num_checks = 0;
  always #20 clk = ~clk; // 25 MHz
  dfe_entry_builder DUT (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_REQ(req), .I_NAME_VALID(nv), .I_NAME(nm),
    .I_START_ADDR(st), .I_BLOCK_COUNT(bc), .I_SIZE_VALID(sv), .I_BYTE_LENGTH(len), .I_BLOCK_BYTES(32'h200),
    .I_DATE_CHARS(dt), .I_DATE_KNOWN(dk), .I_CTIME_CHARS(ct), .I_CTIME_KNOWN(ck), .I_CLOSE_CHARS(cl),
    .I_CLOSE_KNOWN(lk), .I_TIME_TYPE(tt), .I_SLOTS_PER_BLOCK(16'h3), .I_DELETE(del), .I_DELETE_INDEX(di),
    .I_OUT_READY(rdy), .O_BUSY(busy), .O_BYTE_VALID(ov), .O_BYTE(ob), .O_LAST(last), .O_DONE(done),
    .O_ERROR(err), .O_DIR_BLOCK_INDEX(dir), .O_SLOT_INDEX(slot), .O_ENTRY_COUNT(ecnt));
  dfe_media_sink u_sink (.i_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_valid(ov), .i_byte(ob), .o_ready(rdy),
    .o_img(img));
  // Compare and count
  task automatic chk(input logic [895:0] got, input logic [895:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value differs", $time);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Field image: first character on top, unknown ones dashed
  function automatic logic [63:0] fld(input logic [63:0] v, input logic [7:0] m);
    for (int k = 0; k < 8; k++) fld[63-8*k -: 8] = m[k] ? v[8*k +: 8] : 8'h2D;
  endfunction
  // Eight random digit characters
  function automatic logic [63:0] digs();
    for (int k = 0; k < 8; k++) digs[8*k +: 8] = 8'h30 + 8'($unsigned($random(seed)) % 10);
  endfunction
  // One entry request; a default name drives scrambled name input
  task automatic run(input logic ok, input logic v, input logic [447:0] n, input logic [63:0] s, input logic [63:0] c,
    input logic z, input logic [63:0] l, input logic [7:0] t);
    int w;
    @(posedge clk);
    nv <= v; nm <= v ? n : ~n; st <= s; bc <= c; sv <= z; len <= l; tt <= t; slow <= 1'($random(seed));
    dt <= digs(); ct <= digs(); cl <= digs();
    dk <= 8'($random(seed)); ck <= 8'($random(seed)); lk <= 8'($random(seed));
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    w = 0;
    while (done !== 1'b1 && err !== 1'b1 && w < 600) begin
      @(posedge clk);
      w++;
    end
    chk(err, !ok);
    chk(w >= 600, 1'b0);
    chk(busy, 1'b0);
    if (ok) chk(img, {n, s, c, z ? l : {8{8'hFF}}, fld(dt, dk), fld(ct, ck), t, {7{8'hFF}}, fld(cl, lk)});
    @(posedge clk);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    run(1'b1, 1'b0, {8'h31, 440'h0}, 64'h64, 64'hA, 1'b1, 64'h1400, 8'h00);
    chk({dir, slot, ecnt}, {64'h1, 16'h1, 16'h1});
    run(1'b0, 1'b1, {8'h42, 440'h0}, 64'h69, 64'hA, 1'b0, 64'h0, 8'h01);
    run(1'b0, 1'b1, {8'h31, 440'h0}, 64'h12C, 64'h2, 1'b0, 64'h0, 8'h01);
    run(1'b0, 1'b1, {8'h43, 440'h0}, 64'h12C, 64'h2, 1'b1, 64'h401, 8'h01);
    run(1'b0, 1'b1, {8'h44, 440'h0}, 64'h12C, 64'h2, 1'b0, 64'h0, 8'h02 + 8'($unsigned($random(seed)) % 253));
    run(1'b1, 1'b1, {8'h45, 440'h0}, 64'h0, 64'h5, 1'b0, 64'h0, 8'h01);
    chk({dir, slot, ecnt}, {64'h1, 16'h2, 16'h2});
    @(posedge clk);
    del <= 1'b1;
    @(posedge clk);
    del <= 1'b0;
    run(1'b1, 1'b1, {8'h46, 440'h0}, 64'h64, 64'hA, 1'b0, 64'h0, 8'hFF);
    run(1'b1, 1'b0, {8'h32, 440'h0}, 64'h190, 64'h1, 1'b1, 64'h1, 8'h00);
    chk({dir, slot, ecnt}, {64'h2, 16'h1, 16'h1});
    test_done();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
